// ### src/vvc_pkg.sv
// Shared constants and types for the voice VLAN classifier
`default_nettype none
package vvc_pkg;
	// Structure
	localparam int NPORT     = 8;
	localparam int PORT_W    = 3;
	localparam int NOUI      = 8;
	localparam int MAC_W     = 48;
	localparam int OUI_W     = 24;
	localparam int VID_W     = 12;
	localparam int PCP_W     = 3;
	localparam int AGE_W     = 17;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int STRB_W    = 4;
	localparam int MIN_CNT_W = 31;
	// Timing
	localparam int CLK_HZ     = 20_000_000;
	localparam int MINUTE_S   = 60;
	localparam int MINUTE_CYC = CLK_HZ * MINUTE_S;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_VID    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_AGE    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PEN    = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_PMODE  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STAT   = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_MGMT   = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_MVR    = 8'h1c;
	localparam logic [ADDR_W-1:0] PVID_BASE  = 8'h40;
	localparam logic [ADDR_W-1:0] OUI_BASE   = 8'h80;
	localparam int                WORD_B     = 4;
	localparam int                OUI_STRIDE = 8;
	// Field positions
	localparam int CTRL_GEN_BIT  = 0;
	localparam int CTRL_RWEN_BIT = 1;
	localparam int CTRL_PCP_LSB  = 4;
	localparam int STAT_CONF_BIT = 0;
	localparam int STAT_ACT_BIT  = 1;
	localparam int STAT_MEMB_LSB = 8;
	localparam int OUI_OK_BIT    = 31;
	// Reset values and limits
	localparam logic [VID_W-1:0] VID_NONE = 12'h000;
	localparam logic [VID_W-1:0] VID_MIN  = 12'h001;
	localparam logic [VID_W-1:0] PVID_RST = 12'h001;
	localparam logic [VID_W-1:0] MGMT_RST = 12'h001;
	localparam logic [VID_W-1:0] MVR_RST  = 12'h000;
	localparam logic [AGE_W-1:0] AGE_MIN  = 17'h0001e;
	localparam logic [AGE_W-1:0] AGE_MAX  = 17'h10000;
	localparam logic [AGE_W-1:0] AGE_RST  = 17'h005a0;
	localparam logic [PCP_W-1:0] PCP_RST  = 3'h6;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef logic [VID_W-1:0] vvc_vid_t;
	typedef logic [OUI_W-1:0] vvc_oui_t;
endpackage
`default_nettype wire

// ### src/vvc_age_if.sv
// Per-port aging timer connection
`timescale 1ns/100ps
`default_nettype none
interface vvc_age_if;
	import vvc_pkg::*;
	logic             hit;
	logic             tick;
	logic             clr;
	logic [AGE_W-1:0] age;
	logic             member;
	modport timer (input hit, input tick, input clr, input age, output member);
	modport ctl (output hit, output tick, output clr, output age, input member);
endinterface
`default_nettype wire

// ### src/vvc_oui_match.sv
// Source prefix lookup against the telephony prefix table
`timescale 1ns/100ps
`default_nettype none
module vvc_oui_match (
	// Lookup key
	input  wire logic [vvc_pkg::OUI_W-1:0] i_oui,
	// Table contents
	input  wire logic [vvc_pkg::OUI_W-1:0] i_tab [vvc_pkg::NOUI],
	input  wire logic [vvc_pkg::NOUI-1:0]  i_tab_ok,
	// Result
	output logic                           o_hit
);
	import vvc_pkg::*;
	// Live table, so an edit takes effect on the next frame
	always_comb begin
		o_hit = 1'b0;
		for (int i = 0; i < NOUI; i++) begin
			if (i_tab_ok[i] && (i_tab[i] == i_oui)) begin
				o_hit = 1'b1; // RL9
			end
		end
	end
endmodule // vvc_oui_match
`default_nettype wire

// ### src/vvc_age_timer.sv
// Per-port voice VLAN membership with minute-based aging
`timescale 1ns/100ps
`default_nettype none
module vvc_age_timer (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rstn,
	// Control and membership
	vvc_age_if.timer  bus
);
	import vvc_pkg::*;
	logic             member_q;
	logic             member_d;
	logic [AGE_W-1:0] cnt_q;
	logic [AGE_W-1:0] cnt_d;
	logic [AGE_W-1:0] cnt_inc;

	always_comb begin
		member_d = member_q;
		cnt_d    = cnt_q;
		cnt_inc  = cnt_q + AGE_W'(1);
		if (bus.clr) begin
			member_d = 1'b0;
			cnt_d    = '0;
		end else if (bus.hit) begin
			// Hit wins over an expiry in the same cycle
			member_d = 1'b1; // RL13
			cnt_d    = '0; // RL13
		end else if (bus.tick && member_q) begin
			if (cnt_inc >= bus.age) begin
				member_d = 1'b0; // RL6
				cnt_d    = '0;
			end else begin
				cnt_d = cnt_inc;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			member_q <= 1'b0;
			cnt_q    <= '0;
		end else begin
			member_q <= member_d;
			cnt_q    <= cnt_d;
		end
	end

	assign bus.member = member_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	AST_JOIN_ON_HIT: assert property (bus.hit && !bus.clr |=> member_q && (cnt_q == '0)) // RL13
		else $error("Port did not join voice VLAN on voice frame");
	AST_AGE_OUT: assert property (member_q && bus.tick && !bus.hit && !bus.clr && (cnt_q + AGE_W'(1) >= bus.age) // RL6
		|=> !member_q)
		else $error("Port not removed after aging time");
	AST_AGE_HOLD: assert property (member_q && !bus.tick && !bus.hit && !bus.clr |=> member_q && $stable(cnt_q)) // RL6
		else $error("Aging counter moved without minute tick");
endmodule // vvc_age_timer
`default_nettype wire

// ### src/vvc_classifier.sv
// Voice VLAN classifier top with AXI4-Lite configuration
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// (RL1) Frames on voice-enabled ports whose source prefix is in the table are marked voice and put in the voice VLAN.
// (RL2) A global on/off switch, off after reset, gates all voice classification.
// (RL3) One system-wide voice VLAN id is held and only values 1 to 4095 are accepted.
// (RL4) A voice id equal to any port default, management or multicast registration VLAN is flagged as conflict.
// (RL5) Software must turn off the spanning tree function before switching voice VLAN on.
// (RL6) A port leaves the voice VLAN after the aging time without voice frames, 30 to 65536 minutes, default 1440.
// (RL7) With rewriting on, voice frame priority is replaced by the selected value, default 6; rewriting is off at reset.
// (RL8) Each table entry holds a three-octet vendor prefix and a short free-text description.
// (RL9) Entries are added, edited and deleted one by one and lookups use the stored contents.
// (RL10) Each port has a participation enable, off after reset, and only enabled ports are classified.
// (RL11) Each port has a priority mode, all traffic or source-matched, source-matched after reset.
// (RL12) Source-matched mode applies voice priority only to matching frames, all-traffic mode to every frame.
// (RL13) A matching voice frame adds its port to the voice VLAN and restarts its aging timer.
module vvc_classifier #(
	parameter int unsigned P_MINUTE_CYCLES = vvc_pkg::MINUTE_CYC
) (
	// Clock and reset
	input  wire logic                         i_clk,
	input  wire logic                         i_rstn,
	// AXI4-Lite write channels
	input  wire logic [vvc_pkg::ADDR_W-1:0]   i_axi_awaddr,
	input  wire logic                         i_axi_awvalid,
	output logic                              o_axi_awready,
	input  wire logic [vvc_pkg::DATA_W-1:0]   i_axi_wdata,
	input  wire logic [vvc_pkg::STRB_W-1:0]   i_axi_wstrb,
	input  wire logic                         i_axi_wvalid,
	output logic                              o_axi_wready,
	output logic [1:0]                        o_axi_bresp,
	output logic                              o_axi_bvalid,
	input  wire logic                         i_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [vvc_pkg::ADDR_W-1:0]   i_axi_araddr,
	input  wire logic                         i_axi_arvalid,
	output logic                              o_axi_arready,
	output logic [vvc_pkg::DATA_W-1:0]        o_axi_rdata,
	output logic [1:0]                        o_axi_rresp,
	output logic                              o_axi_rvalid,
	input  wire logic                         i_axi_rready,
	// Ingress frame descriptors
	input  wire logic                         i_frm_valid,
	input  wire logic [vvc_pkg::PORT_W-1:0]   i_frm_port,
	input  wire logic [vvc_pkg::MAC_W-1:0]    i_frm_smac,
	input  wire logic [vvc_pkg::VID_W-1:0]    i_frm_vid,
	input  wire logic [vvc_pkg::PCP_W-1:0]    i_frm_pcp,
	// Classified descriptors
	output logic                              o_cls_valid,
	output logic [vvc_pkg::PORT_W-1:0]        o_cls_port,
	output logic                              o_cls_voice,
	output logic [vvc_pkg::VID_W-1:0]         o_cls_vid,
	output logic [vvc_pkg::PCP_W-1:0]         o_cls_pcp,
	output logic [vvc_pkg::NPORT-1:0]         o_port_member
);
	import vvc_pkg::*;

	// Configuration state
	logic                 gen_q, gen_d;
	logic                 rwen_q, rwen_d;
	logic [PCP_W-1:0]     rwpcp_q, rwpcp_d;
	vvc_vid_t             vid_q, vid_d;
	logic [AGE_W-1:0]     age_q, age_d;
	logic [NPORT-1:0]     pen_q, pen_d;
	logic [NPORT-1:0]     pmode_q, pmode_d;
	vvc_vid_t             mgmt_q, mgmt_d;
	vvc_vid_t             mvr_q, mvr_d;
	vvc_vid_t             pvid_q [NPORT];
	vvc_vid_t             pvid_d [NPORT];
	vvc_oui_t             oui_q [NOUI];
	vvc_oui_t             oui_d [NOUI];
	logic [NOUI-1:0]      ouiv_q, ouiv_d;
	logic [DATA_W-1:0]    desc_q [NOUI];
	logic [DATA_W-1:0]    desc_d [NOUI];
	// Bus state
	logic                 aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [ADDR_W-1:0]    awa_q, awa_d;
	logic [DATA_W-1:0]    wd_q, wd_d;
	logic [STRB_W-1:0]    ws_q, ws_d;
	logic                 awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
	logic [1:0]           bresp_q, bresp_d, rresp_q, rresp_d;
	logic [DATA_W-1:0]    rdata_q, rdata_d;
	logic                 wr_fire;
	logic [DATA_W-1:0]    wmask, wm;
	// Classifier state
	logic                 cv_q, cv_d, cvoice_q, cvoice_d;
	logic [PORT_W-1:0]    cport_q, cport_d;
	vvc_vid_t             cvid_q, cvid_d;
	logic [PCP_W-1:0]     cpcp_q, cpcp_d;
	logic [MIN_CNT_W-1:0] mcnt_q, mcnt_d;
	logic                 tick_q, tick_d;
	logic                 conflict, active, pen, oui_hit, voice, papply;

	function automatic logic is_map(input logic [ADDR_W-1:0] a);
		logic m;
		m = (a == OFS_CTRL) || (a == OFS_VID) || (a == OFS_AGE) || (a == OFS_PEN) ||
			(a == OFS_PMODE) || (a == OFS_STAT) || (a == OFS_MGMT) || (a == OFS_MVR);
		for (int p = 0; p < NPORT; p++) begin
			m = m || (a == ADDR_W'(PVID_BASE + WORD_B * p));
		end
		for (int i = 0; i < NOUI; i++) begin
			m = m || (a == ADDR_W'(OUI_BASE + OUI_STRIDE * i)) || (a == ADDR_W'(OUI_BASE + OUI_STRIDE * i + WORD_B));
		end
		return m;
	endfunction

	function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] r;
		r = '0;
		case (a)
			OFS_CTRL: begin
				r[CTRL_GEN_BIT]               = gen_q;
				r[CTRL_RWEN_BIT]              = rwen_q;
				r[CTRL_PCP_LSB +: PCP_W]      = rwpcp_q;
			end
			OFS_VID:   r[VID_W-1:0] = vid_q;
			OFS_AGE:   r[AGE_W-1:0] = age_q;
			OFS_PEN:   r[NPORT-1:0] = pen_q;
			OFS_PMODE: r[NPORT-1:0] = pmode_q;
			OFS_STAT: begin
				r[STAT_CONF_BIT]              = conflict;
				r[STAT_ACT_BIT]               = active;
				r[STAT_MEMB_LSB +: NPORT]     = o_port_member;
			end
			OFS_MGMT:  r[VID_W-1:0] = mgmt_q;
			OFS_MVR:   r[VID_W-1:0] = mvr_q;
			default:   r = '0;
		endcase
		for (int p = 0; p < NPORT; p++) begin
			if (a == ADDR_W'(PVID_BASE + WORD_B * p)) begin
				r[VID_W-1:0] = pvid_q[p];
			end
		end
		for (int i = 0; i < NOUI; i++) begin
			if (a == ADDR_W'(OUI_BASE + OUI_STRIDE * i)) begin
				r[OUI_W-1:0]  = oui_q[i];
				r[OUI_OK_BIT] = ouiv_q[i];
			end
			if (a == ADDR_W'(OUI_BASE + OUI_STRIDE * i + WORD_B)) begin
				r = desc_q[i];
			end
		end
		return r;
	endfunction

	// AXI4-Lite slave: address and data taken in either order
	always_comb begin
		aw_have_d = aw_have_q;
		awa_d     = awa_q;
		w_have_d  = w_have_q;
		wd_d      = wd_q;
		ws_d      = ws_q;
		bv_d      = bv_q;
		bresp_d   = bresp_q;
		rv_d      = rv_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		wr_fire   = aw_have_q && w_have_q && !bv_q;
		if (awr_q && i_axi_awvalid) begin
			aw_have_d = 1'b1;
			awa_d     = i_axi_awaddr;
		end
		if (wr_q && i_axi_wvalid) begin
			w_have_d = 1'b1;
			wd_d     = i_axi_wdata;
			ws_d     = i_axi_wstrb;
		end
		if (bv_q && i_axi_bready) begin
			bv_d = 1'b0;
		end
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bv_d      = 1'b1;
			bresp_d   = is_map(awa_q) ? RESP_OKAY : RESP_SLVERR;
		end
		if (rv_q && i_axi_rready) begin
			rv_d = 1'b0;
		end
		if (arr_q && i_axi_arvalid) begin
			rv_d    = 1'b1;
			rdata_d = rd_word(i_axi_araddr);
			rresp_d = is_map(i_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		awr_d = !aw_have_d && !bv_d;
		wr_d  = !w_have_d && !bv_d;
		arr_d = !rv_d;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			aw_have_q <= 1'b0;
			awa_q     <= '0;
			w_have_q  <= 1'b0;
			wd_q      <= '0;
			ws_q      <= '0;
			awr_q     <= 1'b0;
			wr_q      <= 1'b0;
			bv_q      <= 1'b0;
			bresp_q   <= RESP_OKAY;
			arr_q     <= 1'b0;
			rv_q      <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
		end else begin
			aw_have_q <= aw_have_d;
			awa_q     <= awa_d;
			w_have_q  <= w_have_d;
			wd_q      <= wd_d;
			ws_q      <= ws_d;
			awr_q     <= awr_d;
			wr_q      <= wr_d;
			bv_q      <= bv_d;
			bresp_q   <= bresp_d;
			arr_q     <= arr_d;
			rv_q      <= rv_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// Configuration writes, merged through byte strobes
	always_comb begin
		for (int b = 0; b < STRB_W; b++) begin
			wmask[b*8 +: 8] = {8{ws_q[b]}};
		end
		wm      = (rd_word(awa_q) & ~wmask) | (wd_q & wmask);
		gen_d   = gen_q;
		rwen_d  = rwen_q;
		rwpcp_d = rwpcp_q;
		vid_d   = vid_q;
		age_d   = age_q;
		pen_d   = pen_q;
		pmode_d = pmode_q;
		mgmt_d  = mgmt_q;
		mvr_d   = mvr_q;
		pvid_d  = pvid_q;
		oui_d   = oui_q;
		ouiv_d  = ouiv_q;
		desc_d  = desc_q;
		if (wr_fire) begin
			case (awa_q)
				OFS_CTRL: begin
					gen_d   = wm[CTRL_GEN_BIT]; // RL2
					rwen_d  = wm[CTRL_RWEN_BIT]; // RL7
					rwpcp_d = wm[CTRL_PCP_LSB +: PCP_W]; // RL7
				end
				OFS_VID: begin
					// Zero would leave voice frames untagged, so it is refused
					if (wm[VID_W-1:0] >= VID_MIN) begin
						vid_d = wm[VID_W-1:0]; // RL3
					end
				end
				OFS_AGE: begin
					if ((wm[AGE_W-1:0] >= AGE_MIN) && (wm[AGE_W-1:0] <= AGE_MAX)) begin
						age_d = wm[AGE_W-1:0]; // RL6
					end
				end
				OFS_PEN:   pen_d   = wm[NPORT-1:0]; // RL10
				OFS_PMODE: pmode_d = wm[NPORT-1:0]; // RL11
				OFS_MGMT:  mgmt_d  = wm[VID_W-1:0];
				OFS_MVR:   mvr_d   = wm[VID_W-1:0];
				default: ;
			endcase
			for (int p = 0; p < NPORT; p++) begin
				if (awa_q == ADDR_W'(PVID_BASE + WORD_B * p)) begin
					pvid_d[p] = wm[VID_W-1:0];
				end
			end
			for (int i = 0; i < NOUI; i++) begin
				if (awa_q == ADDR_W'(OUI_BASE + OUI_STRIDE * i)) begin
					oui_d[i]  = wm[OUI_W-1:0]; // RL8
					ouiv_d[i] = wm[OUI_OK_BIT]; // RL9
				end
				if (awa_q == ADDR_W'(OUI_BASE + OUI_STRIDE * i + WORD_B)) begin
					desc_d[i] = wm; // RL8
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			gen_q   <= 1'b0;
			rwen_q  <= 1'b0;
			rwpcp_q <= PCP_RST;
			vid_q   <= VID_NONE;
			age_q   <= AGE_RST;
			pen_q   <= '0;
			pmode_q <= '0;
			mgmt_q  <= MGMT_RST;
			mvr_q   <= MVR_RST;
			for (int p = 0; p < NPORT; p++) begin
				pvid_q[p] <= PVID_RST;
			end
			for (int i = 0; i < NOUI; i++) begin
				oui_q[i]  <= '0;
				desc_q[i] <= '0;
			end
			ouiv_q  <= '0;
		end else begin
			gen_q   <= gen_d;
			rwen_q  <= rwen_d;
			rwpcp_q <= rwpcp_d;
			vid_q   <= vid_d;
			age_q   <= age_d;
			pen_q   <= pen_d;
			pmode_q <= pmode_d;
			mgmt_q  <= mgmt_d;
			mvr_q   <= mvr_d;
			pvid_q  <= pvid_d;
			oui_q   <= oui_d;
			ouiv_q  <= ouiv_d;
			desc_q  <= desc_d;
		end
	end

	// Conflicting id suspends classification until software fixes it
	always_comb begin
		conflict = (vid_q == mgmt_q) || (vid_q == mvr_q);
		for (int p = 0; p < NPORT; p++) begin
			conflict = conflict || (vid_q == pvid_q[p]); // RL4
		end
		conflict = conflict && (vid_q != VID_NONE);
		active   = gen_q && !conflict && (vid_q != VID_NONE); // RL2
	end

	vvc_oui_match u_match (
		.i_oui    (i_frm_smac[MAC_W-1 -: OUI_W]),
		.i_tab    (oui_q),
		.i_tab_ok (ouiv_q),
		.o_hit    (oui_hit)
	);

	// Frame classification, one cycle latency
	always_comb begin
		pen      = pen_q[i_frm_port];
		voice    = active && pen && oui_hit; // RL1 RL10
		papply   = active && pen && (pmode_q[i_frm_port] || oui_hit); // RL12
		cv_d     = i_frm_valid;
		cvoice_d = i_frm_valid && voice;
		cport_d  = i_frm_valid ? i_frm_port : cport_q;
		cvid_d   = cvid_q;
		cpcp_d   = cpcp_q;
		if (i_frm_valid) begin
			cvid_d = voice ? vid_q : i_frm_vid; // RL1
			cpcp_d = (papply && rwen_q) ? rwpcp_q : i_frm_pcp; // RL7
		end
		tick_d = (mcnt_q == MIN_CNT_W'(P_MINUTE_CYCLES - 1));
		mcnt_d = tick_d ? '0 : mcnt_q + MIN_CNT_W'(1);
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cv_q     <= 1'b0;
			cvoice_q <= 1'b0;
			cport_q  <= '0;
			cvid_q   <= VID_NONE;
			cpcp_q   <= '0;
			mcnt_q   <= '0;
			tick_q   <= 1'b0;
		end else begin
			cv_q     <= cv_d;
			cvoice_q <= cvoice_d;
			cport_q  <= cport_d;
			cvid_q   <= cvid_d;
			cpcp_q   <= cpcp_d;
			mcnt_q   <= mcnt_d;
			tick_q   <= tick_d;
		end
	end

	vvc_age_if age_if [NPORT] ();
	for (genvar p = 0; p < NPORT; p++) begin : g_age
		assign age_if[p].hit     = i_frm_valid && voice && (i_frm_port == PORT_W'(p)); // RL13
		assign age_if[p].tick    = tick_q;
		assign age_if[p].clr     = !active || !pen_q[p]; // RL10
		assign age_if[p].age     = age_q;
		assign o_port_member[p]  = age_if[p].member;
		vvc_age_timer u_tmr (
			.i_clk  (i_clk),
			.i_rstn (i_rstn),
			.bus    (age_if[p])
		);
	end

	assign o_axi_awready = awr_q;
	assign o_axi_wready  = wr_q;
	assign o_axi_bvalid  = bv_q;
	assign o_axi_bresp   = bresp_q;
	assign o_axi_arready = arr_q;
	assign o_axi_rvalid  = rv_q;
	assign o_axi_rdata   = rdata_q;
	assign o_axi_rresp   = rresp_q;
	assign o_cls_valid   = cv_q;
	assign o_cls_voice   = cvoice_q;
	assign o_cls_port    = cport_q;
	assign o_cls_vid     = cvid_q;
	assign o_cls_pcp     = cpcp_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_vid_zero_wr;
		wr_fire && (awa_q == OFS_VID) && (wm[VID_W-1:0] == VID_NONE);
	endsequence

	AST_VOICE_TAG: assert property (i_frm_valid && active && pen && oui_hit // RL1
		|=> o_cls_voice && (o_cls_vid == $past(vid_q)))
		else $error("Matching frame not placed in voice VLAN");
	AST_GLOBAL_OFF: assert property (i_frm_valid && !gen_q |=> !o_cls_voice) // RL2
		else $error("Voice frame marked while globally off");
	AST_VID_ZERO: assert property (s_vid_zero_wr |=> vid_q == $past(vid_q)) // RL3
		else $error("Voice VLAN id zero accepted");
	AST_CONFLICT: assert property (i_frm_valid && (vid_q != VID_NONE) // RL4
		&& ((vid_q == mgmt_q) || (vid_q == pvid_q[i_frm_port])) |-> conflict ##1 !o_cls_voice)
		else $error("Conflicting voice id still classifies");
	AST_REWRITE: assert property (i_frm_valid && papply && rwen_q |=> o_cls_pcp == $past(rwpcp_q)) // RL7
		else $error("Voice priority not rewritten");
	AST_NO_REWRITE: assert property (i_frm_valid && !rwen_q |=> o_cls_pcp == $past(i_frm_pcp)) // RL7
		else $error("Priority changed with rewriting off");
	AST_PORT_OFF: assert property (i_frm_valid && !pen |=> !o_cls_voice) // RL10
		else $error("Disabled port classified as voice");
	AST_MODE_ALL: assert property (i_frm_valid && active && pen && pmode_q[i_frm_port] && !oui_hit && rwen_q // RL11 RL12
		|=> !o_cls_voice && (o_cls_pcp == $past(rwpcp_q)))
		else $error("All-traffic mode did not apply voice priority");
	AST_MODE_SRC: assert property (i_frm_valid && !pmode_q[i_frm_port] && !oui_hit // RL12
		|=> o_cls_pcp == $past(i_frm_pcp))
		else $error("Source mode touched a non-matching frame");
	AST_OUI_DEL: assert property (wr_fire && (awa_q == OUI_BASE) && !wm[OUI_OK_BIT] |=> !ouiv_q[0]) // RL9
		else $error("Prefix entry not deleted");
endmodule // vvc_classifier
`default_nettype wire

// ### testbench/vvc_phone_model.sv
// Frame descriptor source standing in for phones and hosts
`timescale 1ns/100ps
`default_nettype none
module vvc_phone_model (
	// Clock
	input  wire logic                        i_clk,
	// Descriptor out
	output logic                             o_valid,
	output logic [vvc_pkg::PORT_W-1:0]       o_port,
	output logic [vvc_pkg::MAC_W-1:0]        o_smac,
	output logic [vvc_pkg::VID_W-1:0]        o_vid,
	output logic [vvc_pkg::PCP_W-1:0]        o_pcp
);
	import vvc_pkg::*;
	initial begin
		o_valid = 1'b0;
		{o_port, o_smac, o_vid, o_pcp} = '0;
	end
	task automatic send(input logic [2:0] p, input logic [23:0] oui, input logic [2:0] pcp);
		@(posedge i_clk);
		o_valid <= 1'b1;
		{o_port, o_smac, o_vid, o_pcp} <= {p, oui, 24'h123456, 12'h00a, pcp};
		@(posedge i_clk);
		o_valid <= 1'b0;
		// Fields outside a frame never repeat the last one
		{o_port, o_smac, o_vid, o_pcp} <= ~{p, oui, 24'h123456, 12'h00a, pcp};
	endtask
endmodule // vvc_phone_model
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the voice VLAN classifier
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import vvc_pkg::*;
	typedef struct packed {logic [2:0] p; logic [23:0] oui; logic [2:0] pcp; logic [16:0] e;} vvc_row_s;
	logic        clk, rstn, awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry, fv, cv, cvo;
	logic [7:0]  awaddr, araddr, memb;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, wsel;
	logic [1:0]  bresp, rresp, r;
	logic [2:0]  fport, cport, fpcp, cpcp;
	logic [47:0] fsmac;
	logic [11:0] fvid, cvid;
	int          fails, checks, i, n;
	logic [7:0]  ra [6] = '{OFS_CTRL, OFS_VID, OFS_AGE, OFS_PEN, OFS_PMODE, OFS_STAT};
	logic [31:0] rvl [6] = '{32'h60, 32'h0, 32'h5a0, 32'h0, 32'h0, 32'h0};
	vvc_row_s    rows [5] = '{'{3'h0, 24'ha1b2c3, 3'h1, 17'h18327}, '{3'h0, 24'ha1b2c4, 3'h2, 17'h10052},
		'{3'h1, 24'ha1b2c4, 3'h3, 17'h10057}, '{3'h2, 24'ha1b2c3, 3'h4, 17'h10054},
		'{3'h1, 24'ha1b2c3, 3'h0, 17'h18327}};
	vvc_classifier #(.P_MINUTE_CYCLES(20)) vvc_classifier_i (.i_clk(clk), .i_rstn(rstn),
		.i_axi_awaddr(awaddr), .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_wdata(wdata),
		.i_axi_wstrb(wstrb), .i_axi_wvalid(wv), .o_axi_wready(wrd), .o_axi_bresp(bresp),
		.o_axi_bvalid(bv), .i_axi_bready(bry), .i_axi_araddr(araddr), .i_axi_arvalid(arv),
		.o_axi_arready(arr), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rv),
		.i_axi_rready(rry), .i_frm_valid(fv), .i_frm_port(fport), .i_frm_smac(fsmac),
		.i_frm_vid(fvid), .i_frm_pcp(fpcp), .o_cls_valid(cv), .o_cls_port(cport),
		.o_cls_voice(cvo), .o_cls_vid(cvid), .o_cls_pcp(cpcp), .o_port_member(memb));
	vvc_phone_model vvc_phone_model_i (.i_clk(clk), .o_valid(fv), .o_port(fport), .o_smac(fsmac),
		.o_vid(fvid), .o_pcp(fpcp));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic report_and_stop;
		if (fails == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("Error %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic hung(input int k);
		if (k >= 50) begin
			fails++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		@(posedge clk);
		{awaddr, wdata, wstrb} <= {a, v, wsel};
		{awv, wv, bry} <= 3'b111;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wrd)
				wv <= 1'b0;
			if (bv)
				break;
		end
		bry <= 1'b0;
		hung(k);
		chk(32'(bresp), 32'(RESP_OKAY));
	endtask
	task automatic rd(input logic [7:0] a);
		int k;
		@(posedge clk);
		araddr <= a;
		{arv, rry} <= 2'b11;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (arr)
				arv <= 1'b0;
			if (rv)
				break;
		end
		{d, r} = {rdata, rresp};
		rry <= 1'b0;
		hung(k);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask
	task automatic frm(input logic [2:0] p, input logic [23:0] oui, input logic [2:0] pcp, input logic [16:0] e);
		vvc_phone_model_i.send(p, oui, pcp);
		#1;
		chk(32'({cv, cvo, cvid, cpcp}), 32'(e));
		chk(32'(cport), 32'(p));
	endtask
	initial begin
		{awaddr, wdata, wstrb, araddr, awv, wv, bry, arv, rry} = '0;
		wsel = 4'hf;
		rstn = 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 6; i++)
			rchk(ra[i], rvl[i]);
		rd(8'h3c);
		chk(d, 32'h0);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(OUI_BASE, 32'h80a1b2c3);
		wr(OUI_BASE + 8'h04, 32'h656e6f68);
		rchk(OUI_BASE + 8'h04, 32'h656e6f68);
		wr(OFS_VID, 32'h64);
		wr(OFS_VID, 32'h0);
		rchk(OFS_VID, 32'h64);
		wr(OFS_PEN, 32'h3);
		wr(OFS_PMODE, 32'h2);
		frm(3'h0, 24'ha1b2c3, 3'h1, 17'h10051);
		// Spanning tree is taken as already off here
		wr(OFS_CTRL, 32'h73);
		for (i = 0; i < 5; i++)
			frm(rows[i].p, rows[i].oui, rows[i].pcp, rows[i].e);
		rchk(OFS_STAT, 32'h302);
		wr(OFS_AGE, 32'd30);
		wr(OFS_AGE, 32'd29);
		rchk(OFS_AGE, 32'd30);
		frm(3'h0, 24'ha1b2c3, 3'h1, 17'h18327);
		// Tick phase is free running, so only a window is checked
		repeat (560) @(posedge clk);
		chk(32'(memb[0]), 32'h1);
		for (n = 0; n < 80 && memb[0] !== 1'b0; n++)
			@(posedge clk);
		chk(32'(memb[0]), 32'h0);
		if (n >= 80)
			report_and_stop();
		frm(3'h0, 24'ha1b2c3, 3'h1, 17'h18327);
		wr(PVID_BASE, 32'h64);
		rchk(OFS_STAT, 32'h1);
		frm(3'h0, 24'ha1b2c3, 3'h1, 17'h10051);
		wr(PVID_BASE, 32'h1);
		wr(OUI_BASE, 32'h80d4e5f6);
		frm(3'h0, 24'hd4e5f6, 3'h1, 17'h18327);
		frm(3'h0, 24'ha1b2c3, 3'h1, 17'h10051);
		wr(OUI_BASE, 32'h00d4e5f6);
		frm(3'h0, 24'hd4e5f6, 3'h1, 17'h10051);
		// Only the second byte lane is written
		wsel = 4'h2;
		wr(OFS_VID, 32'h00000265);
		wsel = 4'hf;
		rchk(OFS_VID, 32'h264);
		// Mid-run reset drops membership and restores defaults
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'({cv, memb}), 32'h0);
		rstn <= 1'b1;
		rchk(OFS_CTRL, 32'h60);
		rchk(OFS_VID, 32'h0);
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
